// >>> can_buffer_status_and_acceptance_filter_test.sv
// self-checking bench for the buffer status and acceptance filter block
`timescale 1ns/1ps
module can_buffer_status_and_acceptance_filter_test;
	import cbf_pkg::*;
	localparam logic [7:0] B0 = CBF_A_BCS_BASE;
	localparam logic [7:0] B1 = B0 + 8'h04;
	localparam logic [7:0] B2 = B0 + 8'h08;
	localparam logic [7:0] F0 = CBF_A_FLT_BASE;
	localparam logic [7:0] F1 = F0 + 8'h10;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic        core_rx_id_valid, core_rx_rtr, core_rx_ok, core_tx_start;
	logic        core_tx_done, core_ifs2, rx_store;
	logic [1:0]  core_tx_buf, rx_buf;
	logic [2:0]  tx_pending;
	logic [7:0]  paddr;
	logic [10:0] core_rx_id;
	logic [31:0] pwdata, prdata, rdq;
	int          err_total, check_count, cyc;

	cbf_buffer_filter #(.NBUF(3), .NFILT(2)) DUT
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .core_rx_id_valid(core_rx_id_valid), .core_rx_id(core_rx_id),
		.core_rx_rtr(core_rx_rtr), .core_rx_ok(core_rx_ok), .core_tx_start(core_tx_start),
		.core_tx_buf(core_tx_buf), .core_tx_done(core_tx_done), .core_ifs2(core_ifs2),
		.tx_pending(tx_pending), .rx_store(rx_store), .rx_buf(rx_buf)
	);
	cbf_core_model core
	(
		.pclk(pclk), .core_rx_id_valid(core_rx_id_valid), .core_rx_id(core_rx_id),
		.core_rx_rtr(core_rx_rtr), .core_rx_ok(core_rx_ok), .core_tx_start(core_tx_start),
		.core_tx_buf(core_tx_buf), .core_tx_done(core_tx_done), .core_ifs2(core_ifs2)
	);

	// ****
	// helpers
	// ****
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			err_total++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("mismatches %0d of %0d checks", err_total, check_count);
		if (err_total == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// request held until pready; the wait is bounded only by the global timeout
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rdq = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		check(name, rdq, {24'h0, exp});
	endtask

	// ****
	// scenarios
	// ****
	task automatic t_reset();
		rchk("bcs0", B0, CBF_RST_BYTE);
		rchk("pat_hi0", F0 + CBF_O_PAT_HI, CBF_RST_BYTE);
		apb(1'b0, 8'hfc, 8'h00);
		check("unmapped", {31'h0, rerr}, 32'h1);
	endtask
	task automatic t_rx();
		apb(1'b1, F0 + CBF_O_PAT_HI, 8'h24);
		apb(1'b1, F0 + CBF_O_PAT_LO, 8'h60);
		apb(1'b1, F0 + CBF_O_CARE_HI, 8'hff);
		apb(1'b1, F0 + CBF_O_CARE_LO, 8'hff);
		apb(1'b1, F1 + CBF_O_PAT_HI, 8'h24);
		apb(1'b1, F1 + CBF_O_CARE_HI, 8'hff);
		rchk("care_lo0", F0 + CBF_O_CARE_LO, 8'hf0);
		rchk("pat_lo0", F0 + CBF_O_PAT_LO, 8'h60);
		fork
			core.frame(1'b0, 11'h123, 1'b0, 1'b1, 8);
			begin
				repeat (2) @(posedge pclk);
				apb(1'b1, B0, 8'h01);
				rchk("busy0", B0, 8'h02);
				check("store", {29'h0, rx_store, rx_buf}, 32'h4);
			end
		join
		rchk("acc0", B0, 8'h04);
		core.frame(1'b0, 11'h123, 1'b1, 1'b1, 2);
		rchk("acc1", B1, 8'h0c);
		core.frame(1'b0, 11'h323, 1'b0, 1'b1, 2);
		rchk("nomatch", B2, 8'h00);
		rchk("receive_irq_flag", CBF_A_IRQ, 8'h03);
	endtask
	task automatic t_release();
		apb(1'b1, CBF_A_IRQ, 8'h02);
		rchk("acc_clr", B1, 8'h04);
		apb(1'b1, B0, 8'h00);
		rchk("rel0", B0, 8'h00);
		rchk("receive_irq_flag_clr", CBF_A_IRQ, 8'h00);
		core.frame(1'b0, 11'h123, 1'b0, 1'b1, 2);
		rchk("refill0", B0, 8'h04);
	endtask
	task automatic t_tx();
		apb(1'b1, B2, 8'h01);
		apb(1'b1, B2, 8'h05);
		rchk("txreq", B2, 8'h05);
		check("txp", {29'h0, tx_pending}, 32'h4);
		core.frame(1'b0, 11'h123, 1'b0, 1'b1, 2);
		rchk("held", B2, 8'h05);
		core.frame(1'b1, 11'h002, 1'b0, 1'b1, 2);
		rchk("sent", B2, 8'h01);
		apb(1'b1, CBF_A_CTRL, 8'h01);
		apb(1'b1, B2, 8'h05);
		core.frame(1'b1, 11'h002, 1'b0, 1'b1, 2);
		rchk("sent_early", B2, 8'h00);
	endtask
	task automatic t_cancel();
		apb(1'b1, CBF_A_CTRL, 8'h00);
		apb(1'b1, B2, 8'h01);
		apb(1'b1, B2, 8'h05);
		rchk("pend", B2, 8'h05);
		apb(1'b1, B2, 8'h00);
		rchk("cancel", B2, 8'h00);
		check("txp_off", {29'h0, tx_pending}, 32'h0);
		core.frame(1'b0, 11'h123, 1'b0, 1'b1, 2);
		rchk("reopen", B2, 8'h04);
	endtask

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		{err_total, check_count, cyc} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_rx();
		t_release();
		t_tx();
		t_cancel();
		complete_run();
	end
endmodule

// >>> cbf_buffer_filter.sv
// buffer control/status flags and acceptance filtering with an apb register port
`timescale 1ns/1ps
module cbf_buffer_filter
	import cbf_pkg::*;
#(
	parameter int NBUF  = 3,
	parameter int NFILT = 2
)
(
	// clock and reset
	input  wire logic            pclk,
	input  wire logic            presetn,
	// apb slave
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [7:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output      logic [31:0]     prdata,
	output      logic            pready,
	output      logic            pslverr,
	// protocol core, receive side
	input  wire logic            core_rx_id_valid,
	input  wire logic [10:0]     core_rx_id,
	input  wire logic            core_rx_rtr,
	input  wire logic            core_rx_ok,
	// protocol core, transmit side
	input  wire logic            core_tx_start,
	input  wire logic [1:0]      core_tx_buf,
	input  wire logic            core_tx_done,
	// protocol core, frame end (second intermission bit)
	input  wire logic            core_ifs2,
	// to protocol core
	output      logic [NBUF-1:0] tx_pending,
	output      logic            rx_store,
	output      logic [1:0]      rx_buf
);

	// ****************************************
	// elaboration checks
	// ****************************************
	// the core names a buffer with a two bit index, so four buffers at most
	if (NBUF < 1 || NBUF > 4)
		$error("NBUF must lie between 1 and 4");
	if (NFILT != 2)
		$error("NFILT must be 2");

	// ****************************************
	// apb decode
	// ****************************************
	function automatic logic is_bcs(input logic [7:0] a, input int b);
		is_bcs = (a == CBF_A_BCS_BASE + 8'(4 * b));
	endfunction

	function automatic logic is_flt(input logic [7:0] a, input int f, input logic [7:0] o);
		is_flt = (a == CBF_A_FLT_BASE + 8'(CBF_FLT_STRIDE * f) + o);
	endfunction

	logic        pready_ff;
	logic [31:0] prdata_ff;
	logic        pslverr_ff;
	logic        access;
	logic        wr_en;
	logic        wr_ctrl;
	logic        wr_irq;
	logic        hit_any;
	logic [31:0] rd_mux;

	// one wait state: pready rises in the second access cycle
	assign access = psel & penable;
	assign wr_en  = access & pready_ff & pwrite;
	assign wr_ctrl = wr_en & (paddr == CBF_A_CTRL);
	assign wr_irq  = wr_en & (paddr == CBF_A_IRQ);

	// ****************************************
	// control register
	// ****************************************
	logic early_ff;
	logic nxt_early;

	assign nxt_early = wr_ctrl ? pwdata[CBF_B_EARLY] : early_ff;

	// ****************************************
	// filter registers
	// ****************************************
	logic [7:0] pat_hi_ff  [NFILT];
	logic [7:0] pat_lo_ff  [NFILT];
	logic [7:0] care_hi_ff [NFILT];
	logic [7:0] care_lo_ff [NFILT];
	logic [NFILT-1:0] flt_hit;
	logic [NFILT-1:0] flt_sel [4];
	logic [31:0] flt_rd [NFILT];

	genvar gf;
	generate
		for (gf = 0; gf < NFILT; gf++)
		begin : g_flt
			assign flt_sel[0][gf] = is_flt(paddr, gf, CBF_O_PAT_HI);
			assign flt_sel[1][gf] = is_flt(paddr, gf, CBF_O_PAT_LO);
			assign flt_sel[2][gf] = is_flt(paddr, gf, CBF_O_CARE_HI);
			assign flt_sel[3][gf] = is_flt(paddr, gf, CBF_O_CARE_LO);

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					pat_hi_ff[gf]  <= CBF_RST_BYTE;
					pat_lo_ff[gf]  <= CBF_RST_BYTE;
					care_hi_ff[gf] <= CBF_RST_BYTE;
					care_lo_ff[gf] <= CBF_RST_BYTE;
				end
				else
				begin
					if (wr_en & flt_sel[0][gf])
						pat_hi_ff[gf] <= pwdata[7:0];
					// low nibble is reserved and held at zero
					if (wr_en & flt_sel[1][gf])
						pat_lo_ff[gf] <= {pwdata[7:4], 4'h0};
					if (wr_en & flt_sel[2][gf])
						care_hi_ff[gf] <= pwdata[7:0];
					if (wr_en & flt_sel[3][gf])
						care_lo_ff[gf] <= {pwdata[7:4], 4'h0};
				end
			end

			assign flt_rd[gf] = flt_sel[0][gf] ? {24'h0, pat_hi_ff[gf]} :
				flt_sel[1][gf] ? {24'h0, pat_lo_ff[gf]} :
				flt_sel[2][gf] ? {24'h0, care_hi_ff[gf]} :
				flt_sel[3][gf] ? {24'h0, care_lo_ff[gf]} : 32'h0;

			cbf_match u_match
			(
				.pattern ({pat_hi_ff[gf], pat_lo_ff[gf][7:CBF_LO_SH]}),
				.care    ({care_hi_ff[gf], care_lo_ff[gf][7:CBF_LO_SH]}),
				.id      (core_rx_id),
				.rtr     (core_rx_rtr),
				.hit     (flt_hit[gf])
			);
		end
	endgenerate

	// ****************************************
	// core activity tracking
	// ****************************************
	cbf_act_t    act_ff;
	cbf_act_t    nxt_act;
	logic [1:0]  cur_ff;
	logic [1:0]  nxt_cur;
	logic        acc_pend_ff;
	logic        nxt_acc_pend;
	logic [NBUF-1:0] free;
	logic        any_free;
	logic [1:0]  free_idx;
	logic        accept;
	logic        rx_take;
	logic        tx_take;
	logic [NBUF-1:0] lock_ff;
	logic [NBUF-1:0] rdy_ff;
	logic [NBUF-1:0] receive_irq_flag_ff;
	logic [NBUF-1:0] acc_ff;
	logic [NBUF-1:0] busy;

	// first free unheld, empty buffer takes the frame
	always_comb
	begin
		free_idx = 2'h0;
		for (int i = NBUF - 1; i >= 0; i--)
		begin
			if (free[i])
				free_idx = 2'(i);
		end
	end

	assign any_free = |free;
	assign accept   = |flt_hit;
	assign rx_take  = (act_ff == CBF_IDLE) & core_rx_id_valid & accept & any_free;
	assign tx_take  = (act_ff == CBF_IDLE) & core_tx_start & ~core_rx_id_valid
		& lock_ff[core_tx_buf] & rdy_ff[core_tx_buf];

	always_comb
	begin
		nxt_act      = act_ff;
		nxt_cur      = cur_ff;
		nxt_acc_pend = acc_pend_ff;
		unique case (act_ff)
			CBF_IDLE:
			begin
				if (rx_take)
				begin
					nxt_act      = CBF_RX;
					nxt_cur      = free_idx;
					nxt_acc_pend = ~flt_hit[0];
				end
				else if (tx_take)
				begin
					nxt_act = CBF_TX;
					nxt_cur = core_tx_buf;
				end
			end
			CBF_RX, CBF_TX:
			begin
				if (core_ifs2)
					nxt_act = CBF_IDLE;
			end
			default:
				nxt_act = CBF_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			act_ff      <= CBF_IDLE;
			cur_ff      <= 2'h0;
			acc_pend_ff <= 1'b0;
		end
		else
		begin
			act_ff      <= nxt_act;
			cur_ff      <= nxt_cur;
			acc_pend_ff <= nxt_acc_pend;
		end
	end

	// ****************************************
	// per buffer flags
	// ****************************************
	logic [NBUF-1:0] bcs_sel;
	logic [31:0]     bcs_rd [NBUF];

	genvar gb;
	generate
		for (gb = 0; gb < NBUF; gb++)
		begin : g_buf
			logic wr_b;
			logic lock_ok;
			logic set_rx;
			logic set_tx;
			logic clr_sw;
			logic clr_hw;
			logic tx_ok;
			logic clr_irq;
			logic nxt_lock;
			logic nxt_rdy;
			logic nxt_receive_irq_flag;
			logic nxt_acc;

			assign bcs_sel[gb] = is_bcs(paddr, gb);
			assign wr_b        = wr_en & bcs_sel[gb];
			assign busy[gb]    = (act_ff != CBF_IDLE) & (cur_ff == 2'(gb));
			assign free[gb]    = ~lock_ff[gb] & ~rdy_ff[gb] & ~busy[gb];

			// a hold change during busy is dropped silently
			assign lock_ok = wr_b & ~busy[gb];
			assign tx_ok   = core_tx_done & (act_ff == CBF_TX) & busy[gb];
			assign set_rx  = core_rx_ok & (act_ff == CBF_RX) & busy[gb] & ~lock_ff[gb];
			assign set_tx  = wr_b & lock_ff[gb] & pwdata[CBF_B_RDY];
			assign clr_sw  = wr_b & ~lock_ff[gb] & ~pwdata[CBF_B_RDY];
			assign clr_hw  = tx_ok | (lock_ok & lock_ff[gb] & ~pwdata[CBF_B_LOCK]);
			assign clr_irq = clr_sw | (wr_irq & pwdata[gb]);

			always_comb
			begin
				nxt_lock = lock_ff[gb];
				if (tx_ok & early_ff)
					nxt_lock = 1'b0;
				else if (lock_ok)
					nxt_lock = pwdata[CBF_B_LOCK];
			end

			// hardware set wins over any clear in the same cycle
			assign nxt_rdy  = (set_rx | set_tx) ? 1'b1 :
				(clr_sw | clr_hw) ? 1'b0 : rdy_ff[gb];
			assign nxt_receive_irq_flag = set_rx ? 1'b1 : clr_irq ? 1'b0 : receive_irq_flag_ff[gb];
			assign nxt_acc  = set_rx ? acc_pend_ff :
				((rdy_ff[gb] & ~nxt_rdy) | (receive_irq_flag_ff[gb] & ~nxt_receive_irq_flag)) ? 1'b0 :
				acc_ff[gb];

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					lock_ff[gb] <= 1'b0;
					rdy_ff[gb]  <= 1'b0;
					receive_irq_flag_ff[gb] <= 1'b0;
					acc_ff[gb]  <= 1'b0;
				end
				else
				begin
					lock_ff[gb] <= nxt_lock;
					rdy_ff[gb]  <= nxt_rdy;
					receive_irq_flag_ff[gb] <= nxt_receive_irq_flag;
					acc_ff[gb]  <= nxt_acc;
				end
			end

			// upper nibble always reads zero
			assign bcs_rd[gb] = {28'h0, acc_ff[gb], rdy_ff[gb], busy[gb], lock_ff[gb]};
		end
	endgenerate

	// ****************************************
	// read mux and bus answer
	// ****************************************
	// filter words read zero unless addressed, so they can simply be or-ed in
	assign hit_any = (paddr == CBF_A_CTRL) | (paddr == CBF_A_IRQ) | (|bcs_sel)
		| (|(flt_sel[0] | flt_sel[1] | flt_sel[2] | flt_sel[3]));

	always_comb
	begin
		rd_mux = 32'h0;
		if (paddr == CBF_A_CTRL)
			rd_mux = {31'h0, early_ff};
		else if (paddr == CBF_A_IRQ)
			rd_mux = 32'(receive_irq_flag_ff);
		for (int i = 0; i < NBUF; i++)
			if (bcs_sel[i])
				rd_mux = bcs_rd[i];
		for (int f = 0; f < NFILT; f++)
			rd_mux = rd_mux | flt_rd[f];
	end

	// ****************************************
	// registered outputs and control
	// ****************************************
	logic [NBUF-1:0] tx_pending_ff;
	logic            rx_store_ff;
	logic [1:0]      rx_buf_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff     <= 1'b0;
			prdata_ff     <= 32'h0;
			pslverr_ff    <= 1'b0;
			early_ff      <= 1'b0;
			tx_pending_ff <= '0;
			rx_store_ff   <= 1'b0;
			rx_buf_ff     <= 2'h0;
		end
		else
		begin
			pready_ff     <= access & ~pready_ff;
			prdata_ff     <= (access & ~pready_ff & ~pwrite) ? rd_mux : 32'h0;
			pslverr_ff    <= access & ~pready_ff & ~hit_any;
			early_ff      <= nxt_early;
			tx_pending_ff <= lock_ff & rdy_ff;
			rx_store_ff   <= (nxt_act == CBF_RX);
			rx_buf_ff     <= nxt_cur;
		end
	end

	assign prdata     = prdata_ff;
	assign pready     = pready_ff;
	assign pslverr    = pslverr_ff;
	assign tx_pending = tx_pending_ff;
	assign rx_store   = rx_store_ff;
	assign rx_buf     = rx_buf_ff;

endmodule

// >>> cbf_buffer_filter_chk.sv
// port-level assertions for the buffer status and acceptance filter block
`timescale 1ns/1ps
module cbf_buffer_filter_chk
	import cbf_pkg::*;
#(
	parameter int NBUF = 3
)
(
	// clock and reset
	input wire logic            pclk,
	input wire logic            presetn,
	// apb
	input wire logic            psel,
	input wire logic            penable,
	input wire logic            pwrite,
	input wire logic [31:0]     prdata,
	input wire logic            pready,
	input wire logic            pslverr,
	// protocol core
	input wire logic            core_rx_id_valid,
	input wire logic            core_ifs2,
	input wire logic [NBUF-1:0] tx_pending,
	input wire logic            rx_store,
	input wire logic [1:0]      rx_buf
);
	// ****
	// checks
	// ****
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_wait; psel && !penable |=> !pready ##1 pready; endproperty
	a_wait: assert property (p_wait) else $error("apb answer not after one wait state");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("slave error outside answer");
	property p_rdata; !pready |-> prdata == 32'h0; endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside answer");
	property p_start; $rose(rx_store) |-> $past(core_rx_id_valid); endproperty
	a_start: assert property (p_start) else $error("fill without identifier");
	property p_stay; rx_store && !core_ifs2 |=> rx_store; endproperty
	a_stay: assert property (p_stay) else $error("fill ended early");
	property p_end; rx_store && core_ifs2 |=> !rx_store; endproperty
	a_end: assert property (p_end) else $error("fill kept past frame end");
	property p_range; rx_store |-> rx_buf < NBUF; endproperty
	a_range: assert property (p_range) else $error("fill into absent buffer");
	property p_held; $rose(rx_store) |-> !tx_pending[rx_buf]; endproperty
	a_held: assert property (p_held) else $error("fill into held buffer");
	property p_txrise; $rose(tx_pending[NBUF-1]) |-> $past(pwrite && pready, 2); endproperty
	a_txrise: assert property (p_txrise) else $error("request without write");
	c_fill: cover property ($rose(rx_store));
	c_req: cover property ($rose(tx_pending[NBUF-1]));
	c_err: cover property (pslverr);
endmodule

bind cbf_buffer_filter cbf_buffer_filter_chk #(.NBUF(NBUF)) u_chk
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .core_ifs2(core_ifs2),
	.core_rx_id_valid(core_rx_id_valid), .tx_pending(tx_pending),
	.rx_store(rx_store), .rx_buf(rx_buf)
);

// >>> cbf_core_model.sv
// behavioural protocol core driving the core side of the block
`timescale 1ns/1ps
module cbf_core_model
(
	// clock
	input wire logic    pclk,
	// frame events
	output logic        core_rx_id_valid,
	output logic [10:0] core_rx_id,
	output logic        core_rx_rtr,
	output logic        core_rx_ok,
	output logic        core_tx_start,
	output logic [1:0]  core_tx_buf,
	output logic        core_tx_done,
	output logic        core_ifs2
);
	initial
	begin
		{core_rx_id_valid, core_rx_id, core_rx_rtr, core_rx_ok} = '0;
		{core_tx_start, core_tx_buf, core_tx_done, core_ifs2} = '0;
	end
	// gap stretches the frame body, so prompt and slow frames share one task
	task automatic frame(input logic tx, input logic [10:0] id, input logic rtr,
		input logic ok, input int gap);
		@(posedge pclk);
		core_tx_start <= tx;
		core_tx_buf <= id[1:0];
		core_rx_id_valid <= !tx;
		core_rx_id <= id;
		core_rx_rtr <= rtr;
		@(posedge pclk);
		core_tx_start <= 1'b0;
		core_rx_id_valid <= 1'b0;
		// released lines show the inverse, never a stale identifier
		core_rx_id <= ~id;
		core_rx_rtr <= ~rtr;
		repeat (gap) @(posedge pclk);
		core_rx_ok <= ok & !tx;
		core_tx_done <= ok & tx;
		@(posedge pclk);
		core_rx_ok <= 1'b0;
		core_tx_done <= 1'b0;
		repeat (gap) @(posedge pclk);
		core_ifs2 <= 1'b1;
		@(posedge pclk);
		core_ifs2 <= 1'b0;
	endtask
endmodule

// >>> cbf_match.sv
// one acceptance pattern/care comparator
`timescale 1ns/1ps
module cbf_match
	import cbf_pkg::*;
(
	// stored pattern and care bits
	input  wire logic [CBF_PAT_W-1:0] pattern,
	input  wire logic [CBF_PAT_W-1:0] care,
	// incoming identifier and remote bit
	input  wire logic [10:0]          id,
	input  wire logic                 rtr,
	// result
	output      logic                 hit
);

	logic [CBF_PAT_W-1:0] in_vec;
	logic [CBF_PAT_W-1:0] ok_bits;

	assign in_vec  = {id, rtr};
	assign ok_bits = ~care | ~(pattern ^ in_vec);
	assign hit     = &ok_bits;

endmodule

// >>> cbf_pkg.sv
// constants, register map and types for the can buffer status and acceptance filter block
// Operation
// - stored frame loads acceptance code 0 on pair 0 match, else 1
// - acceptance code clears when ready flag or receive irq flag clears
// - ready sets on error-free receive (unheld) or pending transmit (held)
// - software clearing ready of unheld buffer frees it and clears its irq flag
// - held buffer ready clears once its transmission is serviced or cancelled
// - busy is high while core fills or empties buffer, drops after intermission bit 2
// - busy stays low whenever the core is not using the buffer
// - setting hold stops reception, keeps contents, offers buffer for transmit
// - clearing hold reopens reception and cancels a pending transmission
// - hold clears by hardware after good transmit only in early transmit mode
// - hold writes are ignored while the buffer is busy
// - twelve bit pattern compared with identifier and remote bit; match stores frame
// - care bit 0 ignores that bit, care bit 1 demands equality
// - pattern bits 11:4 in high register 7:0, bits 3:0 in low register 7:4
// - care low register holds bits 3:0 at 7:4, low nibble reads zero
package cbf_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] CBF_A_CTRL     = 8'h00;
	localparam logic [7:0] CBF_A_IRQ      = 8'h04;
	localparam logic [7:0] CBF_A_BCS_BASE = 8'h10;
	localparam logic [7:0] CBF_A_FLT_BASE = 8'h20;
	localparam int         CBF_FLT_STRIDE = 16;
	localparam logic [7:0] CBF_O_PAT_HI   = 8'h00;
	localparam logic [7:0] CBF_O_PAT_LO   = 8'h04;
	localparam logic [7:0] CBF_O_CARE_HI  = 8'h08;
	localparam logic [7:0] CBF_O_CARE_LO  = 8'h0c;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CBF_B_LOCK  = 0;
	localparam int CBF_B_BUSY  = 1;
	localparam int CBF_B_RDY   = 2;
	localparam int CBF_B_ACC   = 3;
	localparam int CBF_B_EARLY = 0;
	localparam int CBF_PAT_W   = 12;
	localparam int CBF_LO_SH   = 4;
	localparam logic [7:0] CBF_RST_BYTE = 8'h00;

	// ****************************************
	// core activity, gray along idle-rx / idle-tx
	// ****************************************
	typedef enum logic [1:0]
	{
		CBF_IDLE = 2'b00,
		CBF_RX   = 2'b01,
		CBF_TX   = 2'b10
	} cbf_act_t;

endpackage
